// *** core/sdma_map.svh ***
// register indices, field positions and reset values of the six-channel dma controller
// Contract
// - six channels each hold independent context
// - dma memory request beats cpu request
// - per-channel high/low level, round robin
// - per-side hold, increment, decrement or index
// - transfers may wait for selected sync event
// - double word is two accesses, one element
// - address map ignores processor mode bits
// - auto_reload_enable reloads source, destination, count
// - global reloads used only at block boundary
// - frame counter drops on frame's last read
// - auto_reload_enable reloads frame counter from global
// - element counter drops after each element's final read
// - auto_reload_enable reloads element counter from global
// - index select picks step register pair
// - element step applied except frame's last
// - frame step applied on frame's last transfer
// - interrupt off, or half/full buffer modes
// - multi-frame interrupt at block or frame end
// - sub-address pointer, auto-increment port advances
`ifndef SDMA_MAP_SVH
`define SDMA_MAP_SVH
`define SDMA_IDX_PRIORITY   8'h54
`define SDMA_IDX_SUBADDR    8'h55
`define SDMA_IDX_DATA_INC   8'h56
`define SDMA_IDX_DATA_HOLD  8'h57
`define SDMA_SUB_CH_LAST    6'h1d
`define SDMA_SUB_STEP_E0    6'h20
`define SDMA_SUB_STEP_E1    6'h21
`define SDMA_SUB_STEP_F0    6'h22
`define SDMA_SUB_STEP_F1    6'h23
`define SDMA_SUB_GSRC       6'h24
`define SDMA_SUB_GDST       6'h25
`define SDMA_SUB_GCNT       6'h26
`define SDMA_SUB_GFRM       6'h27
`define SDMA_PRI_HIGH_LSB   8
`define SDMA_MCR_AUTO       15
`define SDMA_MCR_IE         14
`define SDMA_MCR_TIMING     13
`define SDMA_MCR_ABU        12
`define SDMA_MCR_DWORD      11
`define SDMA_MCR_SMODE_LSB  8
`define SDMA_MCR_SSEL       7
`define SDMA_MCR_DMODE_LSB  3
`define SDMA_MCR_DSEL       2
`define SDMA_SFC_SYNC_LSB   12
`define SDMA_RESET_WORD     16'h0000
`define SDMA_RESET_SUB      6'h00
`endif

// *** core/sdma_pkg.sv ***
// types shared by the dma controller
package sdma_pkg;
   typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} sdma_state_e;
   typedef logic [15:0] sdma_word_t;
endpackage

// *** core/sdma_controller.sv ***
// six-channel dma controller with apb register port and 16-bit memory master
`timescale 1ns/1ps
`include "sdma_map.svh"
module sdma_controller
   import sdma_pkg::*;
#(
   parameter int NCH = 6
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             mem_req,
   output logic             mem_we,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   input  wire logic        cpu_req,
   output logic             cpu_grant,
   input  wire logic [14:0] sync_events,
   output logic [NCH-1:0]   channel_irq
);
   // per-channel context, shared step and reload registers, engine state
   sdma_word_t  src      [NCH];
   sdma_word_t  dst      [NCH];
   sdma_word_t  ctr      [NCH];
   sdma_word_t  einit    [NCH];
   sdma_word_t  sfc      [NCH];
   sdma_word_t  mcr      [NCH];
   sdma_word_t  estep    [2];
   sdma_word_t  fstep    [2];
   sdma_word_t  gsrc;
   sdma_word_t  gdst;
   sdma_word_t  gcnt;
   sdma_word_t  gfrm;
   logic [NCH-1:0] chan_en;
   logic [NCH-1:0] chan_high;
   logic [NCH-1:0] sync_pend;
   logic [5:0]  sub;
   sdma_state_e state;
   logic [2:0]  cur;
   logic        word1;
   logic        last_x;
   logic        blk_x;
   logic [2:0]  rr_hi;
   logic [2:0]  rr_lo;

   // apb decode
   logic [7:0]  reg_idx;
   logic        bus_wr;
   logic        bus_acc;
   logic        mapped;
   logic        data_port;
   assign reg_idx   = paddr[9:2];
   assign mapped    = paddr[31:10] == 22'h0 && paddr[1:0] == 2'h0 && reg_idx >= `SDMA_IDX_PRIORITY
                      && reg_idx <= `SDMA_IDX_DATA_HOLD;
   assign bus_acc   = psel && penable && mapped;
   assign bus_wr    = bus_acc && pwrite && pstrb[1:0] == 2'h3;
   assign data_port = reg_idx == `SDMA_IDX_DATA_INC || reg_idx == `SDMA_IDX_DATA_HOLD;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;

   // sub-address decoding shared by read mux and write path
   function automatic logic [2:0] sub_chan(input logic [5:0] s);
      sub_chan = 3'(s / 6'd5);
   endfunction
   function automatic logic [2:0] sub_field(input logic [5:0] s);
      sub_field = 3'(s % 6'd5);
   endfunction

   // round-robin search starting after the last served channel
   function automatic logic [3:0] rr_pick(input logic [NCH-1:0] req, input logic [2:0] last);
      logic [2:0] c;
      rr_pick = 4'h0;
      c       = last;
      for (int i = 0; i < NCH; i++) begin
         c = (c == 3'(NCH - 1)) ? 3'h0 : c + 3'h1;
         if (req[c] && !rr_pick[3]) begin
            rr_pick = {1'b1, c};
         end
      end
   endfunction

   // new address after one access on one side
   function automatic sdma_word_t step_addr(input sdma_word_t a, input logic [1:0] mode, input logic sel,
                                            input logic last, input sdma_word_t e0, input sdma_word_t e1,
                                            input sdma_word_t f0, input sdma_word_t f1);
      sdma_word_t amt;
      amt = last ? (sel ? f1 : f0) : (sel ? e1 : e0);
      case (mode)
         2'd0: step_addr = a;
         2'd1: step_addr = a + 16'h0001;
         2'd2: step_addr = a - 16'h0001;
         default: step_addr = a + amt;
      endcase
   endfunction

   // read mux latched in the setup phase so prdata is a flop
   sdma_word_t sub_rd;
   always_comb begin
      sub_rd = `SDMA_RESET_WORD;
      if (sub <= `SDMA_SUB_CH_LAST) begin
         case (sub_field(sub))
            3'd0: sub_rd = src[sub_chan(sub)];
            3'd1: sub_rd = dst[sub_chan(sub)];
            3'd2: sub_rd = ctr[sub_chan(sub)];
            3'd3: sub_rd = sfc[sub_chan(sub)];
            default: sub_rd = mcr[sub_chan(sub)];
         endcase
      end else begin
         case (sub)
            `SDMA_SUB_STEP_E0: sub_rd = estep[0];
            `SDMA_SUB_STEP_E1: sub_rd = estep[1];
            `SDMA_SUB_STEP_F0: sub_rd = fstep[0];
            `SDMA_SUB_STEP_F1: sub_rd = fstep[1];
            `SDMA_SUB_GSRC:    sub_rd = gsrc;
            `SDMA_SUB_GDST:    sub_rd = gdst;
            `SDMA_SUB_GCNT:    sub_rd = gcnt;
            `SDMA_SUB_GFRM:    sub_rd = gfrm;
            default:           sub_rd = `SDMA_RESET_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !mapped) begin
         // refused addresses read as zero even when the index alone would match
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         case (reg_idx)
            `SDMA_IDX_PRIORITY: prdata <= {18'h0, chan_high, 2'h0, chan_en};
            `SDMA_IDX_SUBADDR:  prdata <= {26'h0, sub};
            `SDMA_IDX_DATA_INC, `SDMA_IDX_DATA_HOLD: prdata <= {16'h0, sub_rd};
            default: prdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub <= `SDMA_RESET_SUB;
      end else if (bus_wr && reg_idx == `SDMA_IDX_SUBADDR) begin
         sub <= pwdata[5:0];
      end else if (bus_acc && reg_idx == `SDMA_IDX_DATA_INC) begin
         sub <= sub + 6'h01;
      end
   end

   // arbitration over ready channels
   logic [NCH-1:0] ready_ch;
   logic [3:0]     pick_hi;
   logic [3:0]     pick_lo;
   logic [3:0]     pick;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ready
         assign ready_ch[g] = chan_en[g] && (sfc[g][15:12] == 4'h0 || sync_pend[g]);
      end
   endgenerate
   assign pick_hi = rr_pick(ready_ch & chan_high, rr_hi);
   assign pick_lo = rr_pick(ready_ch & ~chan_high, rr_lo);
   assign pick    = pick_hi[3] ? pick_hi : pick_lo;

   // dma owns memory ahead of cpu
   assign cpu_grant = cpu_req && !mem_req && !(state == ENG_IDLE && pick[3]);

   // engine strobes and per-access decisions
   logic rd_done;
   logic wr_done;
   logic dw;
   logic second;
   logic last_elem;
   logic autobuffering_mode;
   sdma_word_t cmcr;
   assign cmcr      = mcr[cur];
   assign rd_done   = state == ENG_READ && mem_ack;
   assign wr_done   = state == ENG_WRITE && mem_ack;
   assign autobuffering_mode       = cmcr[`SDMA_MCR_ABU];
   assign dw        = cmcr[`SDMA_MCR_DWORD];
   assign second    = !dw || word1;
   assign last_elem = second && ctr[cur] == 16'h0001;

   // one shared engine, six stored contexts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= ENG_IDLE;
         cur       <= 3'h0;
         word1     <= 1'b0;
         last_x    <= 1'b0;
         blk_x     <= 1'b0;
         rr_hi     <= 3'(NCH - 1);
         rr_lo     <= 3'(NCH - 1);
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= 16'h0000;
         mem_wdata <= 16'h0000;
      end else begin
         case (state)
            ENG_IDLE: begin
               if (pick[3]) begin
                  cur      <= pick[2:0];
                  word1    <= 1'b0;
                  mem_req  <= 1'b1;
                  mem_we   <= 1'b0;
                  mem_addr <= src[pick[2:0]];
                  state    <= ENG_READ;
                  if (pick_hi[3]) begin
                     rr_hi <= pick[2:0];
                  end else begin
                     rr_lo <= pick[2:0];
                  end
               end
            end
            ENG_READ: begin
               if (mem_ack) begin
                  mem_we    <= 1'b1;
                  mem_addr  <= dst[cur];
                  mem_wdata <= mem_rdata;
                  last_x    <= last_elem;
                  blk_x     <= last_elem && !autobuffering_mode && sfc[cur][7:0] == 8'h00;
                  state     <= ENG_WRITE;
               end
            end
            ENG_WRITE: begin
               if (mem_ack) begin
                  if (!second) begin
                     word1    <= 1'b1;
                     mem_we   <= 1'b0;
                     mem_addr <= src[cur];
                     state    <= ENG_READ;
                  end else begin
                     mem_req <= 1'b0;
                     mem_we  <= 1'b0;
                     state   <= ENG_IDLE;
                  end
               end
            end
            default: state <= ENG_IDLE;
         endcase
      end
   end

   // sync capture; an event in the consuming cycle survives
   generate
      for (g = 0; g < NCH; g++) begin : g_sync
         logic [3:0] sel;
         assign sel = sfc[g][15:12];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync_pend[g] <= 1'b0;
            end else if (sel != 4'h0 && sync_events[sel - 4'h1]) begin
               sync_pend[g] <= 1'b1;
            end else if (state == ENG_IDLE && pick[3] && pick[2:0] == 3'(g)) begin
               sync_pend[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // enables and levels; software write wins over the hardware stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_en   <= '0;
         chan_high <= '0;
      end else if (bus_wr && reg_idx == `SDMA_IDX_PRIORITY) begin
         chan_en   <= pwdata[NCH-1:0];
         chan_high <= pwdata[`SDMA_PRI_HIGH_LSB +: NCH];
      end else if (wr_done && second && blk_x && !cmcr[`SDMA_MCR_AUTO]) begin
         chan_en[cur] <= 1'b0;
      end
   end

   // shared step and reload registers
   logic sw_sub;
   assign sw_sub = bus_wr && data_port;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         estep[0] <= `SDMA_RESET_WORD;
         estep[1] <= `SDMA_RESET_WORD;
         fstep[0] <= `SDMA_RESET_WORD;
         fstep[1] <= `SDMA_RESET_WORD;
         gsrc     <= `SDMA_RESET_WORD;
         gdst     <= `SDMA_RESET_WORD;
         gcnt     <= `SDMA_RESET_WORD;
         gfrm     <= `SDMA_RESET_WORD;
      end else if (sw_sub) begin
         case (sub)
            `SDMA_SUB_STEP_E0: estep[0] <= pwdata[15:0];
            `SDMA_SUB_STEP_E1: estep[1] <= pwdata[15:0];
            `SDMA_SUB_STEP_F0: fstep[0] <= pwdata[15:0];
            `SDMA_SUB_STEP_F1: fstep[1] <= pwdata[15:0];
            `SDMA_SUB_GSRC:    gsrc <= pwdata[15:0];
            `SDMA_SUB_GDST:    gdst <= pwdata[15:0];
            `SDMA_SUB_GCNT:    gcnt <= pwdata[15:0];
            `SDMA_SUB_GFRM:    gfrm <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // channel context: engine updates, then software writes on top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCH; c++) begin
            src[c]   <= `SDMA_RESET_WORD;
            dst[c]   <= `SDMA_RESET_WORD;
            ctr[c]   <= `SDMA_RESET_WORD;
            einit[c] <= `SDMA_RESET_WORD;
            sfc[c]   <= `SDMA_RESET_WORD;
            mcr[c]   <= `SDMA_RESET_WORD;
         end
      end else begin
         if (rd_done) begin
            src[cur] <= step_addr(src[cur], cmcr[`SDMA_MCR_SMODE_LSB +: 2], cmcr[`SDMA_MCR_SSEL],
                                  last_elem, estep[0], estep[1], fstep[0], fstep[1]);
            if (second) begin
               ctr[cur] <= ctr[cur] - 16'h0001;
               if (last_elem && !autobuffering_mode && sfc[cur][7:0] != 8'h00) begin
                  sfc[cur][7:0] <= sfc[cur][7:0] - 8'h01;
               end
            end
         end
         if (wr_done) begin
            dst[cur] <= step_addr(dst[cur], cmcr[`SDMA_MCR_DMODE_LSB +: 2], cmcr[`SDMA_MCR_DSEL],
                                  second && last_x, estep[0], estep[1], fstep[0], fstep[1]);
            if (second && last_x) begin
               ctr[cur] <= einit[cur];
               if (blk_x && cmcr[`SDMA_MCR_AUTO]) begin
                  src[cur]        <= gsrc;
                  dst[cur]        <= gdst;
                  ctr[cur]        <= gcnt;
                  einit[cur]      <= gcnt;
                  sfc[cur][7:0]   <= gfrm[7:0];
               end
            end
         end
         if (sw_sub && sub <= `SDMA_SUB_CH_LAST) begin
            case (sub_field(sub))
               3'd0: src[sub_chan(sub)] <= pwdata[15:0];
               3'd1: dst[sub_chan(sub)] <= pwdata[15:0];
               3'd2: begin
                  ctr[sub_chan(sub)]   <= pwdata[15:0];
                  einit[sub_chan(sub)] <= pwdata[15:0];
               end
               3'd3: sfc[sub_chan(sub)] <= pwdata[15:0];
               default: mcr[sub_chan(sub)] <= pwdata[15:0];
            endcase
         end
      end
   end

   // interrupt pulses, one cycle after the element's final write
   logic irq_ev;
   logic half_hit;
   assign half_hit = ctr[cur] == {1'b0, einit[cur][15:1]};
   always_comb begin
      irq_ev = 1'b0;
      if (wr_done && second && cmcr[`SDMA_MCR_IE]) begin
         if (autobuffering_mode) begin
            irq_ev = last_x || (cmcr[`SDMA_MCR_TIMING] && half_hit);
         end else begin
            // block end, or every frame end when the timing bit is set
            irq_ev = blk_x || (cmcr[`SDMA_MCR_TIMING] && last_x);
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_irq <= '0;
      end else begin
         channel_irq <= '0;
         if (irq_ev) begin
            channel_irq[cur] <= 1'b1;
         end
      end
   end

endmodule // sdma_controller

// *** verif/sdma_mem_model.sv ***
// memory side model answering the dma master port after a set latency
`timescale 1ns/1ps
module sdma_mem_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   input  wire logic [1:0]  lat,
   output logic [15:0]      mem_rdata,
   output logic             mem_ack
);
   logic [15:0] ram [256];
   logic [1:0]  waited;
   initial for (int i = 0; i < 256; i++) ram[i] = {~8'(i), 8'(i)};
   // one flat map, no mode bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack   <= 1'b0;
         waited    <= 2'h0;
         mem_rdata <= 16'hffff;
      end else if (mem_req && !mem_ack && waited == lat) begin
         mem_ack <= 1'b1;
         waited  <= 2'h0;
         if (mem_we)
            ram[mem_addr[7:0]] <= mem_wdata;
         else
            mem_rdata <= ram[mem_addr[7:0]];
      end else begin
         mem_ack   <= 1'b0;
         // stale read data must never look valid
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack)
            waited <= waited + 2'h1;
      end
   end
endmodule // sdma_mem_model

// *** verif/sdma_controller_checker.sv ***
// port assertions for the dma controller
`timescale 1ns/1ps
module sdma_controller_checker #(
   parameter int NCH = 6
) (
   input wire logic           pclk,
   input wire logic           presetn,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [31:0]    paddr,
   input wire logic [31:0]    pwdata,
   input wire logic [3:0]     pstrb,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire logic           mem_req,
   input wire logic           mem_we,
   input wire logic [15:0]    mem_addr,
   input wire logic [15:0]    mem_wdata,
   input wire logic [15:0]    mem_rdata,
   input wire logic           mem_ack,
   input wire logic           cpu_req,
   input wire logic           cpu_grant,
   input wire logic [14:0]    sync_events,
   input wire logic [NCH-1:0] channel_irq
);
   logic mapped;
   assign mapped = paddr[31:4] == 28'h15 && paddr[1:0] == 2'b00;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_unmapped_refused: assert property (psel && penable && !mapped |-> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_clean: assert property (psel && penable && mapped |-> pready && !pslverr && prdata[31:16] == 16'h0)
      else $error("mapped access answered badly");
   a_dma_beats_cpu: assert property (mem_req |-> !cpu_grant)
      else $error("cpu granted during dma access");
   a_grant_asked: assert property (cpu_grant |-> cpu_req)
      else $error("grant without request");
   a_request_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request changed before ack");
   a_read_feeds_write: assert property (mem_req && !mem_we && mem_ack |=> mem_req && mem_we && mem_wdata == $past(mem_rdata))
      else $error("write does not carry the read word");
   a_read_first: assert property ($rose(mem_req) |-> !mem_we)
      else $error("element began with a write");
   a_irq_single: assert property (|channel_irq |=> channel_irq == '0)
      else $error("interrupt longer than one cycle");
   a_irq_after_write: assert property (|channel_irq |-> $past(mem_we && mem_ack) || $past(mem_we && mem_ack, 2))
      else $error("interrupt not tied to a final write");
endmodule // sdma_controller_checker

bind sdma_controller sdma_controller_checker #(.NCH(NCH)) u_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
   .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
   .cpu_req(cpu_req), .cpu_grant(cpu_grant), .sync_events(sync_events), .channel_irq(channel_irq)
);

// *** verif/sdma_controller_tb.sv ***
// self-checking bench for the six-channel dma controller
`timescale 1ns/1ps
module sdma_controller_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        cpu_req = 1'b1, pready, pslverr, mem_req, mem_we, mem_ack, cpu_grant, err;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'hf;
   logic [14:0] sync_events = 15'h0;
   logic [1:0]  lat = 2'h2;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, rd, reads [$];
   logic [5:0]  channel_irq;
   int          fails = 0, checks_done = 0, b, irq_cnt [6] = '{default: 0};
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      for (int c = 0; c < 6; c++) if (channel_irq[c] === 1'b1) irq_cnt[c]++;
      if (mem_req && !mem_we && mem_ack) reads.push_back(mem_addr);
   end
   sdma_controller #(.NCH(6)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .cpu_req(cpu_req), .cpu_grant(cpu_grant), .sync_events(sync_events), .channel_irq(channel_irq));
   sdma_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   function automatic logic [15:0] pat(input logic [7:0] a);
      return {~a, a};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {22'h0, idx, 2'b00};
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // the answer is taken at the rising edge that sees pready high, only the watchdog ends a hang
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata[15:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      xfer(1'b1, idx, d);
   endtask
   task automatic rdr(input logic [7:0] idx);
      xfer(1'b0, idx, 16'h0);
   endtask
   task automatic prog(input int ch, input logic [15:0] s, dst, cnt, sfc, mode);
      wr(8'h55, 16'(5 * ch));
      wr(8'h56, s);
      wr(8'h56, dst);
      wr(8'h56, cnt);
      wr(8'h56, sfc);
      wr(8'h56, mode);
   endtask
   task automatic wait_idle(input logic [5:0] m);
      for (int i = 0; i < 300; i++) begin
         rdr(8'h54);
         if ((rd[5:0] & m) === 6'h0) break;
      end
      check(rd[5:0] & m, 6'h0);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wr(8'h55, 16'h0020);
      for (int i = 0; i < 4; i++) wr(8'h56, 16'(16'h2 << i));
      rdr(8'h55);
      check(rd, 16'h0024);
      wr(8'h55, 16'h0021);
      pstrb <= 4'h1;
      wr(8'h57, 16'h0009);
      pstrb <= 4'hf;
      rdr(8'h57);
      check(rd, 16'h0004);
      rdr(8'h55);
      check(rd, 16'h0021);
      rdr(8'h60);
      check({err, rd}, 17'h10000);
      $display("registers done");
      // steps now: element 2 and 4, frame 8 and 16
      prog(0, 16'h10, 16'h80, 16'h3, 16'h0, 16'h411c);
      wr(8'h54, 16'h0001);
      wait_idle(6'h01);
      for (int k = 0; k < 3; k++) check(u_mem.ram[8'h80 + 4 * k], pat(8'(8'h10 + k)));
      wr(8'h55, 16'h0);
      rdr(8'h56);
      check(rd, 16'h0013);
      rdr(8'h56);
      check(rd, 16'h0098);
      check(irq_cnt[0], 1);
      $display("indexed frame done");
      for (int t = 0; t < 2; t++) begin
         b = irq_cnt[1];
         prog(1, 16'(16'h3f + 16 * t), 16'(16'h90 + 16 * t), 16'h2, 16'h1, 16'(16'h4208 | (t << 13)));
         wr(8'h54, 16'h0002);
         wait_idle(6'h02);
         check(irq_cnt[1] - b, t + 1);
         for (int k = 0; k < 4; k++) check(u_mem.ram[8'h90 + 16 * t + k], pat(8'(8'h3f + 16 * t - k)));
      end
      $display("multi frame done");
      lat <= 2'h0;
      b = reads.size();
      prog(2, 16'h20, 16'ha1, 16'h1, 16'h0, 16'h4910);
      wr(8'h54, 16'h0004);
      wait_idle(6'h04);
      check(reads.size() - b, 2);
      check({u_mem.ram[8'ha1], u_mem.ram[8'ha0]}, {pat(8'h20), pat(8'h21)});
      check(irq_cnt[2], 1);
      $display("double word done");
      lat <= 2'h1;
      prog(3, 16'h40, 16'hb0, 16'h2, 16'h3000, 16'h0008);
      wr(8'h54, 16'h0008);
      b = reads.size();
      for (int e = 0; e < 2; e++) begin
         sync_events <= 15'h7ffb;
         @(posedge pclk);
         sync_events <= 15'h0;
         repeat (20) @(posedge pclk);
         check(reads.size() - b, e);
         sync_events <= 15'h0004;
         @(posedge pclk);
         sync_events <= 15'h0;
      end
      wait_idle(6'h08);
      check(u_mem.ram[8'hb1], pat(8'h40));
      check(irq_cnt[3], 0);
      $display("sync events done");
      prog(1, 16'h70, 16'hf0, 16'h2, 16'h0, 16'h0108);
      prog(4, 16'h50, 16'hc0, 16'h2, 16'h0, 16'h0108);
      prog(5, 16'h60, 16'hd0, 16'h2, 16'h0, 16'h0108);
      b = reads.size();
      wr(8'h54, 16'h2032);
      wait_idle(6'h32);
      check({reads[b], reads[b + 1]}, {16'h60, 16'h61});
      check(reads[b + 2][5] ^ reads[b + 3][5], 1'b1);
      $display("priority done");
      // autobuffering paced by sync events, so each element is counted exactly
      prog(2, 16'h30, 16'hf8, 16'h4, 16'h3000, 16'h7108);
      b = irq_cnt[2];
      wr(8'h54, 16'h0004);
      for (int e = 0; e < 4; e++) begin
         sync_events <= 15'h0004;
         @(posedge pclk);
         sync_events <= 15'h0;
         repeat (20) @(posedge pclk);
         if (e == 1) check(irq_cnt[2] - b, 1);
      end
      check(irq_cnt[2] - b, 2);
      wr(8'h54, 16'h0);
      check(u_mem.ram[8'hfb], pat(8'h33));
      $display("autobuffer done");
      wr(8'h55, 16'h0024);
      for (int i = 0; i < 4; i++) wr(8'h56, 16'({16'h0070, 16'h00e0, 16'h0001, 16'h0} >> (48 - 16 * i)));
      prog(0, 16'h68, 16'he8, 16'h1, 16'h0, 16'hc108);
      b = irq_cnt[0];
      wr(8'h54, 16'h0001);
      for (int i = 0; i < 500 && irq_cnt[0] < b + 2; i++) @(posedge pclk);
      wr(8'h54, 16'h0);
      repeat (20) @(posedge pclk);
      check({u_mem.ram[8'he8], u_mem.ram[8'he0]}, {pat(8'h68), pat(8'h70)});
      check(irq_cnt[0] - b >= 2, 1'b1);
      check(cpu_grant, 1'b1);
      cpu_req <= 1'b0;
      @(posedge pclk);
      check(cpu_grant, 1'b0);
      $display("auto reload done");
      print_verdict();
   end
endmodule // sdma_controller_tb
